// ---- sim/fsg_flash_model.sv ----
// Behavioural flash read path: answers each request with one 128-bit word.
// Assumes one request at a time; the latency input sets the answer delay.
module fsg_flash_model
	import fsg_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic flash_req,
	input wire logic [16:0] flash_addr,
	input wire logic [7:0] lat,
	output logic flash_valid,
	output fsg_sig_t flash_data
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	fsg_waddr_t pend;

	// Stored word at an address: payload plus parity and check bits.
	function automatic fsg_sig_t fword(input fsg_waddr_t a);
		return {32'hA5C30F01 ^ {15'h0, a}, {a, 15'h5A5A}, ~{15'h0, a}, 32'h0F0F0F0F + {15'h0, a}};
	endfunction

	// Latch the request, count the latency, then pulse one word; data churns when idle.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flash_valid <= 1'b0;
			flash_data <= '0;
			cnt <= 0;
			pend <= '0;
		end else begin
			flash_valid <= 1'b0;
			flash_data <= ~flash_data;
			if (flash_req) begin
				cnt <= int'(lat);
				pend <= flash_addr;
			end else if (cnt == 1) begin
				flash_valid <= 1'b1;
				flash_data <= fword(pend);
				cnt <= 0;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule

// ---- sim/fsg_top_tb.sv ----
// Self-checking bench for the flash signature generator.
// Assumes fsg_cfg.svh on the include path and the flash model beside it.
`include "fsg_cfg.svh"
module fsg_top_tb
	import fsg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, sys_rst, reg_wr, reg_rd, irq, flash_req, flash_valid;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [16:0] flash_addr;
	logic [7:0] lat;
	fsg_sig_t flash_data;
	fsg_waddr_t exp_addr;
	int miscompares, tests_run, nreq;

	fsg_top i_fsg_top (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .flash_req(flash_req),
		.flash_addr(flash_addr), .flash_valid(flash_valid), .flash_data(flash_data));
	fsg_flash_model i_fsg_flash_model (.clk(clk), .sys_rst(sys_rst), .flash_req(flash_req),
		.flash_addr(flash_addr), .lat(lat), .flash_valid(flash_valid), .flash_data(flash_data));

	// Clock of 5 ns period.
	always #2.5 clk = ~clk;

	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// Reference signature folded over the model's words, start to stop inclusive.
	function automatic fsg_sig_t ref_sig(input fsg_waddr_t s, input fsg_waddr_t e);
		fsg_sig_t g, w;
		fsg_waddr_t a;
		g = '0;
		a = s;
		do begin
			w = i_fsg_flash_model.fword(a);
			g = {w[127] ^ g[0] ^ g[2] ^ g[27] ^ g[29], w[126:0] ^ g[127:1]};
			a++;
		end while (a != fsg_waddr_t'(e + 17'h1));
		return g;
	endfunction

	// Every request must carry the next ascending address.
	always @(posedge clk) begin
		if (sys_rst === 1'b0 && flash_req === 1'b1) begin
			chk("flash_addr", {15'h0, flash_addr}, {15'h0, exp_addr});
			exp_addr++;
			nreq++;
		end
	end

	// One full generation: program, trigger, poll, read back and clear.
	task automatic run(input fsg_waddr_t s, input fsg_waddr_t e, input logic [7:0] l, input logic m,
		input logic busy);
		logic [31:0] v;
		fsg_sig_t g;
		int n, i;
		n = int'(fsg_waddr_t'(e - s)) + 1;
		g = ref_sig(s, e);
		lat <= l;
		exp_addr = s;
		nreq = 0;
		wr(`FSG_OFF_IRQ_MASK, {29'h0, m, 2'h0});
		wr(`FSG_OFF_START, {15'h0, s});
		wr(`FSG_OFF_STATCLR, 32'h4);
		wr(`FSG_OFF_STOP, 32'h20000 | {15'h0, e});
		if (busy) wr(`FSG_OFF_STOP, 32'h20000 | {15'h0, e + 17'h3});
		v = 32'h0;
		i = 0;
		while (v[2] !== 1'b1 && i < 15 * n + 8) begin
			rd(`FSG_OFF_STAT, v);
			i += 2;
		end
		if (v[2] !== 1'b1) begin
			miscompares++;
			print_verdict();
		end
		chk("fetches", 32'(nreq), 32'(n));
		chk("irq_on", {31'h0, irq}, {31'h0, m});
		wr(`FSG_OFF_IRQ_STAT, 32'h4);
		#1 chk("irq_off", {31'h0, irq}, 32'h0);
		rd(`FSG_OFF_STAT, v);
		chk("done_held", v, 32'h4);
		rd(`FSG_OFF_STOP, v);
		chk("stop_trig", v, {15'h0, e});
		for (i = 0; i < 4; i++) begin
			rd(`FSG_OFF_RES0 + 12'(4 * i), v);
			chk("result", v, g[32 * i +: 32]);
		end
		rd(`FSG_OFF_START, v);
		chk("start_rb", v, {15'h0, s});
		wr(`FSG_OFF_STATCLR, 32'h4);
		rd(`FSG_OFF_STAT, v);
		chk("done_clr", v, 32'h0);
		rd(`FSG_OFF_RES0, v);
		chk("result_held", v, g[31:0]);
	endtask

	// Reset in mid-run aborts the generation and restores the register defaults.
	task automatic reset_mid();
		logic [31:0] v;
		exp_addr = 17'h40;
		wr(`FSG_OFF_START, 32'h40);
		wr(`FSG_OFF_STOP, 32'h20047);
		repeat (6) @(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`FSG_OFF_STAT, v);
		chk("stat_after_rst", v, 32'h0);
		rd(`FSG_OFF_STOP, v);
		chk("stop_after_rst", v, 32'h0);
		rd(`FSG_OFF_START, v);
		chk("start_after_rst", v, 32'h0);
	endtask

	// Reset, register defaults, then single, slow busy and wrapping runs.
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		reg_addr = 12'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		lat = 8'h1;
		miscompares = 0;
		tests_run = 0;
		nreq = 0;
		exp_addr = '0;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`FSG_OFF_STAT, d);
		chk("stat_reset", d, 32'h0);
		rd(12'h100, d);
		chk("unmapped", d, 32'h0);
		run(17'h5, 17'h5, 8'h1, 1'b1, 1'b0);
		run(17'h10, 17'h17, 8'hD, 1'b0, 1'b1);
		run(17'h1FFFE, 17'h1, 8'h3, 1'b1, 1'b0);
		reset_mid();
		print_verdict();
	end
endmodule

// ---- verilog/fsg_cfg.svh ----
// Register offsets, field positions, widths, feedback taps and timing counts for the flash signature generator.
// Assumes inclusion by its bare name from the package and design modules.
`ifndef FSG_CFG_SVH
`define FSG_CFG_SVH
`define FSG_ADDR_W 12
`define FSG_OFF_START 12'h020
`define FSG_OFF_STOP 12'h024
`define FSG_OFF_RES0 12'h02C
`define FSG_OFF_RES1 12'h030
`define FSG_OFF_RES2 12'h034
`define FSG_OFF_RES3 12'h038
`define FSG_OFF_IRQ_STAT 12'h040
`define FSG_OFF_IRQ_MASK 12'h044
`define FSG_OFF_STAT 12'hFE0
`define FSG_OFF_STATCLR 12'hFE8
`define FSG_WADDR_W 17
`define FSG_TRIG_BIT 17
`define FSG_DONE_BIT 2
`define FSG_SIG_W 128
`define FSG_TAP_A 2
`define FSG_TAP_B 27
`define FSG_TAP_C 29
`define FSG_ACCESS_NS 60
`define FSG_CLK_NS 5
`define FSG_CYC_PER_WORD ((`FSG_ACCESS_NS / `FSG_CLK_NS) + 3)
`endif

// ---- verilog/fsg_flash_if.sv ----
// Flash read path carrier between the sequencer and the signature compressor.
// Assumes one clock shared by both ends.
interface fsg_flash_if;
	import fsg_pkg::*;
	logic clear;
	logic word_valid;
	fsg_sig_t word_data;
	fsg_sig_t sig;
	modport seq (output clear, output word_valid, output word_data, input sig);
	modport comp (input clear, input word_valid, input word_data, output sig);
endinterface

// ---- verilog/fsg_misr.sv ----
// Shift-feedback signature compressor, one update per valid flash word.
// Assumes the sequencer raises word_valid once per fetched word.
`include "fsg_cfg.svh"
module fsg_misr
	import fsg_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	fsg_flash_if.comp fl
);
	// ----------------------------------------
	// Compression step
	// ----------------------------------------
	// Computes the next accumulator value from one flash word.
	function automatic fsg_sig_t fsg_step(input fsg_sig_t cur, input fsg_sig_t w);
		fsg_sig_t n;
		n = w ^ {1'b0, cur[`FSG_SIG_W-1:1]}; // RULE9
		n[`FSG_SIG_W-1] = w[`FSG_SIG_W-1] ^ cur[0] ^ cur[`FSG_TAP_A] ^ cur[`FSG_TAP_B] ^ cur[`FSG_TAP_C]; // RULE10
		return n;
	endfunction

	fsg_sig_t acc_q;

	// Clears on start, folds each valid word in.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_q <= '0;
		end else if (fl.clear) begin
			acc_q <= '0; // RULE8
		end else if (fl.word_valid) begin
			acc_q <= fsg_step(acc_q, fl.word_data); // RULE17
		end
	end
	assign fl.sig = acc_q;

	misr_step_a: assert property (@(posedge clk) disable iff (sys_rst)
		fl.word_valid && !fl.clear |=> acc_q == fsg_step($past(acc_q), $past(fl.word_data)))
		else $error("accumulator step wrong"); // RULE9
	misr_clear_a: assert property (@(posedge clk) disable iff (sys_rst) fl.clear |=> acc_q == '0)
		else $error("accumulator not cleared"); // RULE8
endmodule

// ---- verilog/fsg_pkg.sv ----
// Types shared by the flash signature generator modules.
// Assumes fsg_cfg.svh is on the include path.
`include "fsg_cfg.svh"
package fsg_pkg;
	typedef logic [`FSG_WADDR_W-1:0] fsg_waddr_t;
	typedef logic [`FSG_SIG_W-1:0] fsg_sig_t;
	typedef enum logic [1:0] {FSG_IDLE, FSG_FETCH, FSG_WAIT} fsg_state_t;
endpackage

// ---- verilog/fsg_top.sv ----
// Flash signature generator: register port, address sequencer and flash read request.
// Assumes the flash answers each request with one corrected 128-bit word including parity and check bits.
//
// What this block does
// RULE1 - Software programs start and stop word addresses before triggering.
// RULE2 - Writing one to the trigger bit starts generation; stop address in same write.
// RULE3 - Each word finishes within int(60/period+3) cycles, linear in word count.
// RULE4 - A pollable completion flag sits in the status register.
// RULE5 - Signature reads as four 32-bit words, lowest bits first.
// RULE6 - Each compressed word is the corrected flash read data.
// RULE7 - Parity and check bits are part of the compressed word.
// RULE8 - Accumulator clears, then every address start..stop ascending is folded once.
// RULE9 - Next bit i equals word bit i xor accumulator bit i+1.
// RULE10 - Next bit 127 equals word bit 127 xor accumulator bits 0,2,27,29.
// RULE11 - Software compares the signature against its own reference.
// RULE12 - Start and stop addresses are 17-bit flash word indexes.
// RULE13 - Trigger bit 17 clears itself when generation finishes.
// RULE14 - Completion flag at status bit 2 sets on finish and stays.
// RULE15 - Writing one to clear register bit 2 clears the completion flag.
// RULE16 - Results hold until the next trigger; triggers while busy are ignored.
// RULE17 - Exactly one flash word per address; update only on valid data.
`include "fsg_cfg.svh"
module fsg_top
	import fsg_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [`FSG_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	output logic flash_req,
	output logic [`FSG_WADDR_W-1:0] flash_addr,
	input wire logic flash_valid,
	input wire logic [`FSG_SIG_W-1:0] flash_data
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	fsg_flash_if fl ();
	fsg_state_t state_q;
	fsg_waddr_t start_q;
	fsg_waddr_t stop_q;
	fsg_waddr_t cur_q;
	logic trig_q;
	logic done_q;
	logic irq_stat_q;
	logic irq_mask_q;
	fsg_sig_t result_q;
	logic [31:0] rdata_q;
	logic wr_start;
	logic wr_stop;
	logic wr_clr;
	logic wr_istat;
	logic go;
	logic finish;
	logic finish_q;

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	// Decodes register writes and the trigger condition.
	assign wr_start = reg_wr && (reg_addr == `FSG_OFF_START);
	assign wr_stop = reg_wr && (reg_addr == `FSG_OFF_STOP);
	assign wr_clr = reg_wr && (reg_addr == `FSG_OFF_STATCLR);
	assign wr_istat = reg_wr && (reg_addr == `FSG_OFF_IRQ_STAT);
	assign go = wr_stop && reg_wdata[`FSG_TRIG_BIT] && (state_q == FSG_IDLE); // RULE2 RULE16
	assign finish = (state_q == FSG_WAIT) && flash_valid && (cur_q == stop_q);

	// Holds the start and stop word addresses; both are writable only when idle.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			start_q <= '0;
			stop_q <= '0;
		end else begin
			if (wr_start && state_q == FSG_IDLE) begin
				start_q <= reg_wdata[`FSG_WADDR_W-1:0]; // RULE12
			end
			if (wr_stop && state_q == FSG_IDLE) begin
				stop_q <= reg_wdata[`FSG_WADDR_W-1:0]; // RULE12
			end
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Walks addresses upward, one request and one valid word per address.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= FSG_IDLE;
			cur_q <= '0;
		end else begin
			case (state_q)
				FSG_IDLE: begin
					if (go) begin
						cur_q <= start_q; // RULE8
						state_q <= FSG_FETCH;
					end
				end
				FSG_FETCH: begin
					state_q <= FSG_WAIT; // RULE17 RULE3
				end
				FSG_WAIT: begin
					if (flash_valid) begin
						if (cur_q == stop_q) begin
							state_q <= FSG_IDLE;
						end else begin
							cur_q <= cur_q + 17'h00001; // RULE8
							state_q <= FSG_FETCH;
						end
					end
				end
				default: begin
					state_q <= FSG_IDLE;
				end
			endcase
		end
	end

	// Request one word per address from the flash read path.
	assign flash_req = (state_q == FSG_FETCH); // RULE17
	assign flash_addr = cur_q;

	// Connects the compressor; data is the corrected word with parity and check bits.
	assign fl.clear = go; // RULE8
	assign fl.word_valid = (state_q == FSG_WAIT) && flash_valid; // RULE17
	assign fl.word_data = flash_data; // RULE6 RULE7

	fsg_misr u_misr (
		.clk(clk),
		.sys_rst(sys_rst),
		.fl(fl.comp)
	);

	// ----------------------------------------
	// Status and result
	// ----------------------------------------
	// Trigger bit stays high while running and drops at the end.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			trig_q <= 1'b0;
		end else if (go) begin
			trig_q <= 1'b1;
		end else if (finish) begin
			trig_q <= 1'b0; // RULE13
		end
	end

	// Completion flag; a finish in the same cycle as a clear wins.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			done_q <= 1'b0;
		end else if (finish) begin
			done_q <= 1'b1; // RULE14 RULE4
		end else if (wr_clr && reg_wdata[`FSG_DONE_BIT]) begin
			done_q <= 1'b0; // RULE15
		end
	end

	// Sticky interrupt status, write one to clear; set wins.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_stat_q <= 1'b0;
			irq_mask_q <= 1'b0;
		end else begin
			if (finish) begin
				irq_stat_q <= 1'b1;
			end else if (wr_istat && reg_wdata[`FSG_DONE_BIT]) begin
				irq_stat_q <= 1'b0;
			end
			if (reg_wr && reg_addr == `FSG_OFF_IRQ_MASK) begin
				irq_mask_q <= reg_wdata[`FSG_DONE_BIT];
			end
		end
	end
	assign irq = irq_stat_q && irq_mask_q;

	// Remembers that the last word was folded in the previous cycle.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			finish_q <= 1'b0;
		end else begin
			finish_q <= finish;
		end
	end

	// Captures the signature once the last word has settled and holds it until the next run ends.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			result_q <= '0;
		end else if (finish_q) begin
			result_q <= fl.sig; // RULE16
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Read data one cycle after the strobe; unmapped reads return zero.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`FSG_OFF_START: rdata_q <= {15'h0000, start_q};
				`FSG_OFF_STOP: rdata_q <= {14'h0000, trig_q, stop_q};
				`FSG_OFF_RES0: rdata_q <= result_q[31:0]; // RULE5
				`FSG_OFF_RES1: rdata_q <= result_q[63:32];
				`FSG_OFF_RES2: rdata_q <= result_q[95:64];
				`FSG_OFF_RES3: rdata_q <= result_q[127:96];
				`FSG_OFF_STAT: rdata_q <= {29'h0000_0000, done_q, 2'h0}; // RULE4
				`FSG_OFF_IRQ_STAT: rdata_q <= {29'h0000_0000, irq_stat_q, 2'h0};
				`FSG_OFF_IRQ_MASK: rdata_q <= {29'h0000_0000, irq_mask_q, 2'h0};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end
	assign reg_rdata = rdata_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Cycle counter for the per-word time budget.
	logic [7:0] word_cyc_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			word_cyc_q <= 8'h00;
		end else if (state_q == FSG_IDLE || fl.word_valid) begin
			word_cyc_q <= 8'h00;
		end else begin
			word_cyc_q <= word_cyc_q + 8'h01;
		end
	end

	trig_start_a: assert property (@(posedge clk) disable iff (sys_rst)
		go |=> state_q == FSG_FETCH && cur_q == $past(start_q) && trig_q)
		else $error("trigger did not start run"); // RULE2
	busy_ignore_a: assert property (@(posedge clk) disable iff (sys_rst)
		wr_stop && state_q != FSG_IDLE |=> $stable(stop_q))
		else $error("stop changed while busy"); // RULE16
	done_set_a: assert property (@(posedge clk) disable iff (sys_rst) finish |=> done_q && !trig_q)
		else $error("finish not flagged"); // RULE14
	done_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
		wr_clr && reg_wdata[`FSG_DONE_BIT] && !finish |=> !done_q)
		else $error("done not cleared"); // RULE15
	addr_step_a: assert property (@(posedge clk) disable iff (sys_rst)
		fl.word_valid && cur_q != stop_q |=> cur_q == $past(cur_q) + 1'b1)
		else $error("address not ascending"); // RULE8
	one_req_a: assert property (@(posedge clk) disable iff (sys_rst) flash_req |=> !flash_req)
		else $error("double fetch"); // RULE17
	word_time_a: assert property (@(posedge clk) disable iff (sys_rst)
		flash_valid |-> word_cyc_q < 8'(`FSG_CYC_PER_WORD))
		else $error("word exceeded time budget"); // RULE3
	result_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		state_q != FSG_IDLE |=> $stable(result_q))
		else $error("result changed mid run"); // RULE16

	run_c: cover property (@(posedge clk) disable iff (sys_rst) go ##[1:40] finish);
	busy_trig_c: cover property (@(posedge clk) disable iff (sys_rst) wr_stop && state_q != FSG_IDLE);
	irq_c: cover property (@(posedge clk) disable iff (sys_rst) irq);
endmodule
